// >>> pkg/lcsi_pkg.sv
// Purpose: shared constants and types of the cpu sideband block
// Assumes: classic wishbone, 32-bit data, byte addresses
// Notes:   register index times four gives the byte address
package lcsi_pkg;
   // ----------------------------------------
   // timing
   // ----------------------------------------
   localparam int unsigned CLK_PERIOD_NS = 100;
   localparam int unsigned CPU_RST_MIN_US = 2000;
   localparam int unsigned CPU_RST_CYC =
      (CPU_RST_MIN_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

   // ----------------------------------------
   // register map
   // ----------------------------------------
   localparam int ADR_W = 10;
   localparam logic [7:0] IDX_CONFIG   = 8'h00;
   localparam logic [7:0] IDX_ROUTE    = 8'h01;
   localparam logic [7:0] IDX_TRIGGER  = 8'h02;
   localparam logic [7:0] IDX_RESETCTL = 8'h03;
   localparam logic [7:0] IDX_STATUS   = 8'h04;
   localparam logic [7:0] IDX_FASTGATE = 8'h92;
   localparam logic [7:0] IDX_FPUACK   = 8'hF0;

   // config fields
   localparam int CFG_MOUSE = 0;
   localparam int CFG_FPUEN = 1;
   localparam int CFG_SEREN = 2;
   localparam int CFG_W     = 3;
   localparam logic [CFG_W-1:0] CFG_RST = 3'h0;
   // reset control: hard reset request bit
   localparam int RC_HARD = 1;
   // fast gate: mask gate bit
   localparam int FG_GATE = 1;
   localparam logic [7:0] FG_RST = 8'h00;
   // route field: 4 bits per shared line, 0 means not routed
   localparam int RT_W = 4;
   localparam logic [15:0] ROUTE_RST = 16'h0000;
   localparam logic [15:0] TRIG_RST  = 16'h0000;
   // status fields
   localparam int ST_PROCESSOR_RESET_OUT = 16;
   localparam int ST_IGNORE_FPU_ERROR_OUT  = 17;
   localparam int ST_GPI    = 18;
   localparam int ST_MOUSE  = 19;

   // ----------------------------------------
   // interrupt numbers
   // ----------------------------------------
   localparam logic [15:0] ROUTABLE = 16'hDEF8;
   localparam int IRQ_MOUSE = 12;
   localparam int IRQ_FPU   = 13;
   localparam logic [15:0] PORT_KBD_DATA = 16'h0060;

   // ----------------------------------------
   // types
   // ----------------------------------------
   typedef enum logic [1:0] {
      LCSI_HOLD = 2'b01,
      LCSI_RUN  = 2'b10
   } lcsi_fsm_t;

   typedef struct packed {
      logic             cyc;
      logic             stb;
      logic             we;
      logic [ADR_W-1:0] adr;
      logic [3:0]       sel;
      logic [31:0]      dat;
   } lcsi_wbreq_t;

   typedef struct packed {
      lcsi_fsm_t        fsm;
      logic [31:0]      rstCnt;
      logic             strapLow;
      logic [CFG_W-1:0] cfg;
      logic [15:0]      route;
      logic [15:0]      trig;
      logic [7:0]       fastGate;
      logic [15:0]      edgePend;
      logic [15:0]      irqPrev;
      logic             mouseLatch;
      logic             iorPrev;
      logic             ignore_fpu_error_out;
      logic             wbAck;
      logic [31:0]      wbDat;
      logic             procRst;
      logic             processor_interrupt_out;
      logic             a20Oe;
      logic             ignneOe;
      logic             pirqDOe;
      logic             genIn;
   } lcsi_state_t;
endpackage

// >>> logic/lcsi_top.sv
// Purpose: cpu sideband logic: irq steering, mouse latch, mask gate,
//          processor reset timing, coprocessor error handling
// Assumes: all inputs synchronous to ref_clk (pci clock domain)
// Notes:   open-drain pins are out/oe pairs, oe high drives low
// Operation
// - mouse mode latches line twelve rising edge
// - mouse latch clears on reset or 60h read
// - shared inputs active low, level, wired
// - each shared input routes to legal lines
// - usb interrupt drives fourth shared line
// - serial pin becomes general input when unused
// - mask output from fast gate and kbc
// - processor reset held 2 ms after power-good
// - register hard reset asserts reset 2 ms
// - reset released on pci clock rising edge
// - hard reset restores all registers default
// - reset polarity chosen by processor strap
// - coprocessor error raises internal irq 13
// - ignore-error output only when reporting enabled
// - ack write during error asserts ignore-error
// - ignore-error holds until error input negates
// - ack write without error does nothing
// - interrupt output shows pending request
// - legacy inputs edge or level, edge default
`timescale 1ns/1ps
module lcsi_top #(
   parameter int unsigned RESET_CYCLES = lcsi_pkg::CPU_RST_CYC
) (
   input  wire logic                       ref_clk,
   input  wire logic                       reset,
   input  wire logic                       wb_cyc_i,
   input  wire logic                       wb_stb_i,
   input  wire logic                       wb_we_i,
   input  wire logic [lcsi_pkg::ADR_W-1:0] wb_adr_i,
   input  wire logic [3:0]                 wb_sel_i,
   input  wire logic [31:0]                wb_dat_i,
   output logic      [31:0]                wb_dat_o,
   output logic                            wb_ack_o,
   input  wire logic [15:0]                legacyIrqIn,
   input  wire logic                       ioReadStrobe_n,
   input  wire logic [15:0]                ioAddr,
   input  wire logic [3:0]                 sharedIrqIn_n,
   input  wire logic                       usbIrq,
   output logic                            fourthSharedIrqOut,
   output logic                            fourthSharedIrqOe,
   input  wire logic                       serialIrqPinIn,
   output logic                            generalInputAlt,
   input  wire logic                       kbcGateIn,
   output logic                            addrBit20MaskOut,
   output logic                            addrBit20MaskOe,
   input  wire logic                       powerGoodIn,
   input  wire logic                       processorTypeStrap,
   output logic                            processorResetOut,
   input  wire logic                       fpuErrorIn_n,
   output logic                            ignoreFpuErrorOut,
   output logic                            ignoreFpuErrorOe,
   output logic                            processorIntrOut
);
   // ----------------------------------------
   // checks and constants
   // ----------------------------------------
   if (RESET_CYCLES < 1) begin : g_badCycles
      $error("RESET_CYCLES must be at least one");
   end

   localparam logic [31:0] RST_LAST = 32'(RESET_CYCLES - 1);
   localparam logic [lcsi_pkg::ADR_W-1:0] A_CONFIG   = {lcsi_pkg::IDX_CONFIG, 2'b00};
   localparam logic [lcsi_pkg::ADR_W-1:0] A_ROUTE    = {lcsi_pkg::IDX_ROUTE, 2'b00};
   localparam logic [lcsi_pkg::ADR_W-1:0] A_TRIGGER  = {lcsi_pkg::IDX_TRIGGER, 2'b00};
   localparam logic [lcsi_pkg::ADR_W-1:0] A_RESETCTL = {lcsi_pkg::IDX_RESETCTL, 2'b00};
   localparam logic [lcsi_pkg::ADR_W-1:0] A_STATUS   = {lcsi_pkg::IDX_STATUS, 2'b00};
   localparam logic [lcsi_pkg::ADR_W-1:0] A_FASTGATE = {lcsi_pkg::IDX_FASTGATE, 2'b00};
   localparam logic [lcsi_pkg::ADR_W-1:0] A_FPUACK   = {lcsi_pkg::IDX_FPUACK, 2'b00};

   localparam lcsi_pkg::lcsi_state_t RST_VAL = '{
      fsm:      lcsi_pkg::LCSI_HOLD,
      cfg:      lcsi_pkg::CFG_RST,
      route:    lcsi_pkg::ROUTE_RST,
      trig:     lcsi_pkg::TRIG_RST,
      fastGate: lcsi_pkg::FG_RST,
      iorPrev:  1'b1,
      procRst:  1'b1,
      default:  '0
   };

   lcsi_pkg::lcsi_state_t  ff;
   lcsi_pkg::lcsi_state_t  nxt_ff;
   lcsi_pkg::lcsi_wbreq_t  req;

   assign req = '{cyc: wb_cyc_i, stb: wb_stb_i, we: wb_we_i,
                  adr: wb_adr_i, sel: wb_sel_i, dat: wb_dat_i};

   // ----------------------------------------
   // next state
   // ----------------------------------------
   logic        access;
   logic        wrEn;
   logic        hardReq;
   logic        fpuErr;
   logic        iorFall;
   logic [3:0]  sharedLvl;
   logic [15:0] sharedVec;
   logic [15:0] rise;
   logic [15:0] stdSrc;
   logic [15:0] pendVec;
   logic [15:0] clrPend;
   logic [31:0] wmask;
   logic [31:0] rdata;

   always_comb begin
      nxt_ff = ff;
      access = req.cyc && req.stb && !ff.wbAck;
      wrEn = access && req.we;
      wmask = {{8{req.sel[3]}}, {8{req.sel[2]}}, {8{req.sel[1]}}, {8{req.sel[0]}}};
      fpuErr = !fpuErrorIn_n;

      // shared lines: low means asserted, usb adds to line four
      sharedLvl = ~sharedIrqIn_n;
      sharedLvl[3] = sharedLvl[3] | usbIrq;
      sharedVec = 16'h0000;
      for (int i = 0; i < 4; i++) begin
         logic [3:0] num;
         num = ff.route[i*lcsi_pkg::RT_W +: lcsi_pkg::RT_W];
         // illegal numbers route nowhere
         if (sharedLvl[i] && lcsi_pkg::ROUTABLE[num])
            sharedVec[num] = 1'b1;
      end

      // legacy edge detect; edge latches, level passes straight
      rise = legacyIrqIn & ~ff.irqPrev;
      nxt_ff.irqPrev = legacyIrqIn;
      stdSrc = legacyIrqIn & ff.trig & lcsi_pkg::ROUTABLE;
      if (ff.cfg[lcsi_pkg::CFG_MOUSE])
         stdSrc[lcsi_pkg::IRQ_MOUSE] = 1'b0;

      clrPend = 16'h0000;
      if (wrEn && req.adr == A_STATUS)
         clrPend = req.dat[15:0] & wmask[15:0];
      begin
         logic [15:0] setPend;
         setPend = rise & ~ff.trig & lcsi_pkg::ROUTABLE;
         if (ff.cfg[lcsi_pkg::CFG_MOUSE])
            setPend[lcsi_pkg::IRQ_MOUSE] = 1'b0;
         // set wins over a same-cycle clear
         nxt_ff.edgePend = (ff.edgePend & ~clrPend) | setPend;
      end

      // mouse latch
      iorFall = ff.iorPrev && !ioReadStrobe_n;
      nxt_ff.iorPrev = ioReadStrobe_n;
      if (iorFall && ioAddr == lcsi_pkg::PORT_KBD_DATA)
         nxt_ff.mouseLatch = 1'b0;
      if (ff.cfg[lcsi_pkg::CFG_MOUSE] && rise[lcsi_pkg::IRQ_MOUSE])
         nxt_ff.mouseLatch = 1'b1;

      pendVec = ff.edgePend | stdSrc | sharedVec;
      pendVec[lcsi_pkg::IRQ_MOUSE] = pendVec[lcsi_pkg::IRQ_MOUSE] | ff.mouseLatch;
      pendVec[lcsi_pkg::IRQ_FPU] = fpuErr;
      nxt_ff.processor_interrupt_out = |pendVec;

      // ignore-error: set on ack write during error, drops with error
      if (!fpuErr || !ff.cfg[lcsi_pkg::CFG_FPUEN])
         nxt_ff.ignore_fpu_error_out = 1'b0;
      else if (wrEn && req.adr == A_FPUACK)
         nxt_ff.ignore_fpu_error_out = 1'b1;
      nxt_ff.ignneOe = nxt_ff.ignore_fpu_error_out && nxt_ff.cfg[lcsi_pkg::CFG_FPUEN];

      // mask output: assert only with both gates low
      nxt_ff.a20Oe = !ff.fastGate[lcsi_pkg::FG_GATE] && !kbcGateIn;
      nxt_ff.pirqDOe = usbIrq;

      // serial decode lives elsewhere; unused pin is a plain input
      nxt_ff.genIn = ff.cfg[lcsi_pkg::CFG_SEREN] ? 1'b0 : serialIrqPinIn;

      // register writes
      hardReq = 1'b0;
      if (wrEn) begin
         case (req.adr)
            A_CONFIG:
               nxt_ff.cfg = (ff.cfg & ~wmask[lcsi_pkg::CFG_W-1:0]) |
                            (req.dat[lcsi_pkg::CFG_W-1:0] & wmask[lcsi_pkg::CFG_W-1:0]);
            A_ROUTE:
               nxt_ff.route = (ff.route & ~wmask[15:0]) | (req.dat[15:0] & wmask[15:0]);
            A_TRIGGER:
               nxt_ff.trig = (ff.trig & ~wmask[15:0]) | (req.dat[15:0] & wmask[15:0]);
            A_FASTGATE:
               if (req.sel[0])
                  nxt_ff.fastGate = req.dat[7:0];
            A_RESETCTL:
               hardReq = req.sel[0] && req.dat[lcsi_pkg::RC_HARD];
            default: ;
         endcase
      end

      // read mux; unmapped reads give zero
      rdata = 32'h0000_0000;
      case (req.adr)
         A_CONFIG:   rdata[lcsi_pkg::CFG_W-1:0] = ff.cfg;
         A_ROUTE:    rdata[15:0] = ff.route;
         A_TRIGGER:  rdata[15:0] = ff.trig;
         A_FASTGATE: rdata[7:0] = ff.fastGate;
         A_STATUS: begin
            rdata[15:0] = pendVec;
            rdata[lcsi_pkg::ST_PROCESSOR_RESET_OUT] = ff.fsm == lcsi_pkg::LCSI_HOLD;
            rdata[lcsi_pkg::ST_IGNORE_FPU_ERROR_OUT] = ff.ignore_fpu_error_out;
            rdata[lcsi_pkg::ST_GPI] = ff.genIn;
            rdata[lcsi_pkg::ST_MOUSE] = ff.mouseLatch;
         end
         default: ;
      endcase
      nxt_ff.wbAck = access;
      nxt_ff.wbDat = (access && !req.we) ? rdata : 32'h0000_0000;

      // processor reset sequencing
      case (ff.fsm)
         lcsi_pkg::LCSI_HOLD: begin
            // strap taken while the processor sits in reset
            nxt_ff.strapLow = processorTypeStrap;
            if (!powerGoodIn)
               nxt_ff.rstCnt = 32'h0000_0000;
            else if (ff.rstCnt >= RST_LAST)
               nxt_ff.fsm = lcsi_pkg::LCSI_RUN;
            else
               nxt_ff.rstCnt = ff.rstCnt + 32'h0000_0001;
         end
         lcsi_pkg::LCSI_RUN: begin
            if (!powerGoodIn) begin
               nxt_ff.fsm = lcsi_pkg::LCSI_HOLD;
               nxt_ff.rstCnt = 32'h0000_0000;
            end
         end
         default: begin
            nxt_ff.fsm = lcsi_pkg::LCSI_HOLD;
            nxt_ff.rstCnt = 32'h0000_0000;
         end
      endcase

      // hard reset: every register back to default, bus cycle completes
      if (hardReq) begin
         nxt_ff = RST_VAL;
         nxt_ff.strapLow = ff.strapLow;
         nxt_ff.wbAck = 1'b1;
         nxt_ff.irqPrev = legacyIrqIn;
         nxt_ff.iorPrev = ioReadStrobe_n;
         nxt_ff.fsm = lcsi_pkg::LCSI_HOLD;
         // pin followers, not settings: keep tracking through a hard reset
         nxt_ff.pirqDOe = usbIrq;
         nxt_ff.processor_interrupt_out = fpuErr;
      end

      // active high for strap low, active low for strap high
      nxt_ff.procRst = (nxt_ff.fsm == lcsi_pkg::LCSI_HOLD) ^ nxt_ff.strapLow;
   end

   // ----------------------------------------
   // state register
   // ----------------------------------------
   // updates only on the rising edge, so reset release is clock aligned
   always_ff @(posedge ref_clk) begin
      if (reset)
         ff <= RST_VAL;
      else
         ff <= nxt_ff;
   end

   // ----------------------------------------
   // outputs
   // ----------------------------------------
   assign wb_dat_o           = ff.wbDat;
   assign wb_ack_o           = ff.wbAck;
   assign processorResetOut  = ff.procRst;
   assign processorIntrOut   = ff.processor_interrupt_out;
   assign addrBit20MaskOe    = ff.a20Oe;
   assign addrBit20MaskOut   = ff.rstCnt[31] & 1'b0;
   assign ignoreFpuErrorOe   = ff.ignneOe;
   assign ignoreFpuErrorOut  = ff.rstCnt[31] & 1'b0;
   assign fourthSharedIrqOe  = ff.pirqDOe;
   assign fourthSharedIrqOut = ff.rstCnt[31] & 1'b0;
   assign generalInputAlt    = ff.genIn;
endmodule

// >>> testbench/lcsi_top_properties.sv
// Purpose: pin relations of the cpu sideband block
// Assumes: one clock domain, sync active-high reset
// Notes:   register contents are not visible here; the bench covers them
`timescale 1ns/1ps
module lcsi_top_properties #(
   parameter int unsigned RESET_CYCLES = 20
) (
   input wire logic ref_clk,
   input wire logic reset,
   input wire logic usbIrq,
   input wire logic fourthSharedIrqOut,
   input wire logic fourthSharedIrqOe,
   input wire logic serialIrqPinIn,
   input wire logic generalInputAlt,
   input wire logic kbcGateIn,
   input wire logic addrBit20MaskOut,
   input wire logic addrBit20MaskOe,
   input wire logic powerGoodIn,
   input wire logic processorTypeStrap,
   input wire logic processorResetOut,
   input wire logic fpuErrorIn_n,
   input wire logic ignoreFpuErrorOe,
   input wire logic processorIntrOut
);
   int unsigned pgCnt_ff;
   // saturates so a long run never wraps into a short count
   always_ff @(posedge ref_clk) begin
      if (reset || !powerGoodIn) begin
         pgCnt_ff <= 32'h0;
      end else if (pgCnt_ff < 32'hFFFF) begin
         pgCnt_ff <= pgCnt_ff + 32'h1;
      end
   end
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (reset);
   sequence s_errHeld;
      !fpuErrorIn_n [*2];
   endsequence
   sequence s_errGone;
      $rose(fpuErrorIn_n) ##1 fpuErrorIn_n [*2];
   endsequence
   property p_usbDrive; 1'b1 |-> fourthSharedIrqOe == $past(usbIrq) && !fourthSharedIrqOut; endproperty
   property p_gpiCopy; generalInputAlt |-> $past(serialIrqPinIn); endproperty
   property p_maskKbc; kbcGateIn |=> !addrBit20MaskOe && !addrBit20MaskOut; endproperty
   property p_rstMin; $fell(processorResetOut) && !processorTypeStrap |-> pgCnt_ff >= RESET_CYCLES; endproperty
   property p_rstPol; (!powerGoodIn && $stable(processorTypeStrap)) [*3] |-> processorResetOut == !processorTypeStrap;
   endproperty
   property p_intrFpu; s_errHeld |-> processorIntrOut; endproperty
   property p_ignGate; $rose(ignoreFpuErrorOe) |-> $past(!fpuErrorIn_n); endproperty
   property p_ignDrop; s_errGone |=> !ignoreFpuErrorOe; endproperty
   a_usbDrive: assert property (p_usbDrive) else $error("fourth line drive wrong");
   a_gpiCopy: assert property (p_gpiCopy) else $error("general input not from pin");
   a_maskKbc: assert property (p_maskKbc) else $error("mask driven with gate open");
   a_rstMin: assert property (p_rstMin) else $error("reset released early");
   a_rstPol: assert property (p_rstPol) else $error("reset polarity wrong");
   a_intrFpu: assert property (p_intrFpu) else $error("no processor_interrupt_out on coprocessor error");
   a_ignGate: assert property (p_ignGate) else $error("ignore set without error");
   a_ignDrop: assert property (p_ignDrop) else $error("ignore kept after error gone");
endmodule
bind lcsi_top lcsi_top_properties #(.RESET_CYCLES(RESET_CYCLES)) lcsi_top_properties_inst (
   .ref_clk, .reset, .usbIrq, .fourthSharedIrqOut, .fourthSharedIrqOe, .serialIrqPinIn, .generalInputAlt,
   .kbcGateIn, .addrBit20MaskOut, .addrBit20MaskOe, .powerGoodIn, .processorTypeStrap, .processorResetOut,
   .fpuErrorIn_n, .ignoreFpuErrorOe, .processorIntrOut);

// >>> testbench/lcsi_host_model.sv
// Purpose: board side of the sideband pins
// Assumes: open-drain pins pulled up on the board
// Notes:   srcIrq bit high means a board source pulls that shared line low
`timescale 1ns/1ps
module lcsi_host_model (
   input  wire logic [3:0] srcIrq,
   input  wire logic       fourthSharedIrqOe,
   input  wire logic       fourthSharedIrqOut,
   input  wire logic       addrBit20MaskOe,
   input  wire logic       addrBit20MaskOut,
   input  wire logic       ignoreFpuErrorOe,
   input  wire logic       ignoreFpuErrorOut,
   output logic      [3:0] sharedIrqIn_n,
   output logic            a20Pin,
   output logic            ignPin
);
   // any of several drivers pulls a shared line low
   assign sharedIrqIn_n = ~(srcIrq | {fourthSharedIrqOe & ~fourthSharedIrqOut, 3'h0});
   assign a20Pin = addrBit20MaskOe ? addrBit20MaskOut : 1'b1;
   assign ignPin = ignoreFpuErrorOe ? ignoreFpuErrorOut : 1'b1;
endmodule

// >>> testbench/tb_top.sv
// Purpose: directed tests of the cpu sideband block
// Assumes: reset count shortened to RST cycles
// Notes:   outputs are read just after an edge, as sampled at it
`timescale 1ns/1ps
module tb_top;
   localparam int unsigned RST = 20;
   localparam logic [9:0] A_CFG = 10'h000, A_RT = 10'h004, A_TRG = 10'h008, A_RC = 10'h00C;
   localparam logic [9:0] A_ST = 10'h010, A_FG = 10'h248, A_ACK = 10'h3C0;
   logic        ref_clk, reset, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, ioReadStrobe_n, usbIrq;
   logic        fourthSharedIrqOut, fourthSharedIrqOe, serialIrqPinIn, generalInputAlt, kbcGateIn;
   logic        addrBit20MaskOut, addrBit20MaskOe, powerGoodIn, processorTypeStrap, processorResetOut;
   logic        fpuErrorIn_n, ignoreFpuErrorOut, ignoreFpuErrorOe, processorIntrOut, a20Pin, ignPin;
   logic [lcsi_pkg::ADR_W-1:0] wb_adr_i;
   logic [3:0]  wb_sel_i, sharedIrqIn_n, srcIrq;
   logic [31:0] wb_dat_i, wb_dat_o, q;
   logic [15:0] legacyIrqIn, ioAddr;
   logic [9:0]  regs [6] = '{A_CFG, A_RT, A_TRG, A_FG, A_ACK, 10'h100};
   int          err_total, check_count, cycles, n;
   lcsi_top #(.RESET_CYCLES(RST)) lcsi_top_inst (.ref_clk, .reset, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
      .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .legacyIrqIn, .ioReadStrobe_n, .ioAddr, .sharedIrqIn_n, .usbIrq,
      .fourthSharedIrqOut, .fourthSharedIrqOe, .serialIrqPinIn, .generalInputAlt, .kbcGateIn, .addrBit20MaskOut,
      .addrBit20MaskOe, .powerGoodIn, .processorTypeStrap, .processorResetOut, .fpuErrorIn_n,
      .ignoreFpuErrorOut, .ignoreFpuErrorOe, .processorIntrOut);
   lcsi_host_model lcsi_host_model_inst (.srcIrq, .fourthSharedIrqOe, .fourthSharedIrqOut, .addrBit20MaskOe,
      .addrBit20MaskOut, .ignoreFpuErrorOe, .ignoreFpuErrorOut, .sharedIrqIn_n, .a20Pin, .ignPin);
   initial begin
      ref_clk = 1'b0;
      forever #50 ref_clk = ~ref_clk;
   end
   task automatic tick(input int k);
      repeat (k) @(posedge ref_clk);
   endtask
   task automatic bus(input logic w, input logic [9:0] a, input logic [31:0] d);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i <= w;
      wb_adr_i <= a;
      wb_dat_i <= d;
      do @(posedge ref_clk); while (wb_ack_o !== 1'b1);
      q = wb_dat_o;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
      @(posedge ref_clk);
   endtask
   task automatic io_rd(input logic [15:0] a);
      ioAddr <= a;
      ioReadStrobe_n <= 1'b0;
      tick(2);
      ioReadStrobe_n <= 1'b1;
      tick(2);
   endtask
   task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
      check_count++;
      if (s !== e) begin
         err_total++;
         $display("[ERR] %s expected %h seen %h", nm, e, s);
      end
   endtask
   task automatic test_done();
      $display("checks %0d mismatches %0d", check_count, err_total);
      if (err_total == 0 && check_count > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask
   function automatic bit legal(input int k);
      return (k >= 3 && k <= 7) || (k >= 9 && k <= 12) || k >= 14;
   endfunction
   // ceiling well above the few hundred cycles the tests need
   always @(posedge ref_clk) begin
      cycles <= cycles + 1;
      if (cycles == 8000) begin
         err_total++;
         test_done();
      end
   end
   initial begin
      {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i, legacyIrqIn, ioAddr, srcIrq} = '0;
      {usbIrq, serialIrqPinIn, kbcGateIn, powerGoodIn, processorTypeStrap} = '0;
      {ioReadStrobe_n, fpuErrorIn_n, reset} = 3'h7;
      wb_sel_i = 4'hF;
      {err_total, check_count, cycles} = '0;
      tick(6);
      reset <= 1'b0;
      tick(1);
      foreach (regs[i]) begin
         bus(1'b0, regs[i], 32'h0);
         chk("reset value", q, 32'h0);
      end
      bus(1'b0, A_ST, 32'h0);
      chk("status hold", q, 32'h00010000);
      processorTypeStrap <= 1'b1;
      tick(4);
      chk("reset pin", processorResetOut, 1'b0);
      processorTypeStrap <= 1'b0;
      tick(4);
      chk("reset pin", processorResetOut, 1'b1);
      powerGoodIn <= 1'b1;
      n = 0;
      while (processorResetOut === 1'b1) begin
         tick(1);
         n++;
      end
      chk("release delay", n >= RST, 1'b1);
      $display("reset test end");
      serialIrqPinIn <= 1'b1;
      for (int i = 0; i < 4; i++) begin
         bus(1'b1, A_FG, {30'h0, i[1], 1'b0});
         kbcGateIn <= i[0];
         tick(3);
         chk("mask pin", a20Pin, i != 0);
         bus(1'b0, A_FG, 32'h0);
         chk("fast gate", q, {30'h0, i[1], 1'b0});
      end
      chk("general input", generalInputAlt, 1'b1);
      $display("mask test end");
      bus(1'b1, A_TRG, 32'h0000FFFF);
      srcIrq <= 4'h1;
      for (int k = 0; k < 16; k++) begin
         bus(1'b1, A_RT, k);
         tick(2);
         bus(1'b0, A_ST, 32'h0);
         chk("steered", q[15:0], legal(k) ? 16'h1 << k : 16'h0);
      end
      chk("processor_interrupt_out", processorIntrOut, 1'b1);
      srcIrq <= 4'h0;
      tick(3);
      chk("processor_interrupt_out idle", processorIntrOut, 1'b0);
      bus(1'b1, A_RT, 32'h00009000);
      usbIrq <= 1'b1;
      tick(3);
      chk("usb line", sharedIrqIn_n, 4'h7);
      bus(1'b0, A_ST, 32'h0);
      chk("usb steered", q[15:0], 16'h0200);
      usbIrq <= 1'b0;
      bus(1'b1, A_TRG, 32'h0);
      legacyIrqIn <= 16'h0008;
      tick(2);
      legacyIrqIn <= 16'h0000;
      tick(2);
      bus(1'b0, A_ST, 32'h0);
      chk("edge held", q[15:0], 16'h0008);
      bus(1'b1, A_ST, 32'h00000008);
      bus(1'b0, A_ST, 32'h0);
      chk("edge cleared", q[15:0], 16'h0000);
      $display("steering test end");
      bus(1'b1, A_CFG, 32'h1);
      legacyIrqIn <= 16'h1000;
      tick(2);
      legacyIrqIn <= 16'h0000;
      tick(2);
      bus(1'b0, A_ST, 32'h0);
      chk("mouse latch", q & 32'h00081000, 32'h00081000);
      io_rd(16'h0064);
      bus(1'b0, A_ST, 32'h0);
      chk("mouse kept", q[19], 1'b1);
      io_rd(16'h0060);
      bus(1'b0, A_ST, 32'h0);
      chk("mouse cleared", q & 32'h00081000, 32'h0);
      $display("mouse test end");
      bus(1'b1, A_CFG, 32'h2);
      bus(1'b1, A_ACK, 32'h0);
      tick(2);
      chk("ignore idle", ignPin, 1'b1);
      fpuErrorIn_n <= 1'b0;
      tick(3);
      chk("fpu processor_interrupt_out", processorIntrOut, 1'b1);
      bus(1'b1, A_ACK, 32'h0);
      tick(1);
      chk("ignore set", ignPin, 1'b0);
      tick(5);
      chk("ignore held", ignPin, 1'b0);
      fpuErrorIn_n <= 1'b1;
      tick(4);
      chk("ignore gone", ignPin, 1'b1);
      bus(1'b1, A_CFG, 32'h0);
      fpuErrorIn_n <= 1'b0;
      bus(1'b1, A_ACK, 32'h0);
      tick(2);
      chk("ignore off", ignPin, 1'b1);
      fpuErrorIn_n <= 1'b1;
      $display("coprocessor test end");
      bus(1'b1, A_CFG, 32'h4);
      tick(2);
      chk("general input off", generalInputAlt, 1'b0);
      bus(1'b1, A_RC, 32'h2);
      chk("hard reset on", processorResetOut, 1'b1);
      // reset already stood at the ack edge
      n = 1;
      while (processorResetOut === 1'b1) begin
         tick(1);
         n++;
      end
      chk("hard reset", n >= RST, 1'b1);
      bus(1'b0, A_CFG, 32'h0);
      chk("config cleared", q, 32'h0);
      bus(1'b0, A_FG, 32'h0);
      chk("gate cleared", q, 32'h0);
      $display("hard reset test end");
      test_done();
   end
endmodule
